// ==== pfm_defines.svh ====
// constants for the pad function multiplexer
`ifndef PFM_DEFINES_SVH
`define PFM_DEFINES_SVH

`define PFM_PORT_COUNT 4
`define PFM_PINS_PER_PORT 8
`define PFM_CODE_WIDTH 4
`define PFM_CODE_COUNT 16

// reset selection per port, ports a to d
`define PFM_PORT_A_PCTL_RST 32'h0011_1111
`define PFM_PORT_B_PCTL_RST 32'h0000_1100
`define PFM_PORT_C_PCTL_RST 32'h0000_3333
`define PFM_PORT_D_PCTL_RST 32'h0000_0000
`define PFM_PORT_A_AFSEL_RST 8'h00
`define PFM_PORT_B_AFSEL_RST 8'h00
`define PFM_PORT_C_AFSEL_RST 8'h0f
`define PFM_PORT_D_AFSEL_RST 8'h00
`define PFM_PORT_A_DIGEN_RST 8'h3f
`define PFM_PORT_B_DIGEN_RST 8'h0c
`define PFM_PORT_C_DIGEN_RST 8'h0f
`define PFM_PORT_D_DIGEN_RST 8'h00
`define PFM_ANASEL_RST 8'h00

// port d bit 0 and bit 1 positions in the flat pin vector
`define PFM_DB0_IDX 24
`define PFM_DB1_IDX 25

// peripheral mux codes on port d bits 0 and 1
`define PFM_CODE_CMP_OUT 4'h9
`define PFM_CODE_I2C 4'h2
`define PFM_CODE_SSI 4'hf
`define PFM_CODE_TIMER 4'h3

`endif

// ==== pfm_pkg.sv ====
// types shared by the pad function multiplexer
package pfm_pkg;
    typedef enum logic [1:0] {
        PFM_FIELD_DIGEN,
        PFM_FIELD_ANASEL,
        PFM_FIELD_AFSEL,
        PFM_FIELD_PCTL
    } pfm_field_type;
endpackage

// ==== pfm_port_cfg.sv ====
// per-port selection registers with their reset defaults
`timescale 1ns/1ps
`default_nettype none
`include "pfm_defines.svh"
module pfm_port_cfg #(
    parameter logic [7:0] DIGEN_RST = 8'h00,
    parameter logic [7:0] AFSEL_RST = 8'h00,
    parameter logic [7:0] ANASEL_RST = 8'h00,
    parameter logic [31:0] PCTL_RST = 32'h0000_0000
) (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_we,
    input wire pfm_pkg::pfm_field_type i_field,
    input wire logic [31:0] i_wdata,
    output logic [7:0] o_digen,
    output logic [7:0] o_anasel,
    output logic [7:0] o_afsel,
    output logic [31:0] o_pctl
);
    logic [7:0] digen_r, digen_nxt;
    logic [7:0] anasel_r, anasel_nxt;
    logic [7:0] afsel_r, afsel_nxt;
    logic [31:0] pctl_r, pctl_nxt;

    // whole-field write; upper bits of the byte-wide fields are dropped
    always_comb begin
        digen_nxt = digen_r;
        anasel_nxt = anasel_r;
        afsel_nxt = afsel_r;
        pctl_nxt = pctl_r;
        if (i_we) begin
            case (i_field)
                pfm_pkg::PFM_FIELD_DIGEN: digen_nxt = i_wdata[7:0];
                pfm_pkg::PFM_FIELD_ANASEL: anasel_nxt = i_wdata[7:0];
                pfm_pkg::PFM_FIELD_AFSEL: afsel_nxt = i_wdata[7:0];
                default: pctl_nxt = i_wdata;
            endcase
        end
    end

    // reset brings back the default selection
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            digen_r <= DIGEN_RST;
            anasel_r <= ANASEL_RST;
            afsel_r <= AFSEL_RST;
            pctl_r <= PCTL_RST;
        end else begin
            digen_r <= digen_nxt;
            anasel_r <= anasel_nxt;
            afsel_r <= afsel_nxt;
            pctl_r <= pctl_nxt;
        end
    end

    assign o_digen = digen_r;
    assign o_anasel = anasel_r;
    assign o_afsel = afsel_r;
    assign o_pctl = pctl_r;

    a_cfg_write_take: assert property (@(posedge i_clock) disable iff (i_rst)
        i_we && i_field == pfm_pkg::PFM_FIELD_PCTL
        |=> pctl_r == $past(i_wdata))
        else $error("port control write not taken");
endmodule // pfm_port_cfg
`default_nettype wire

// ==== pfm_pad_mux.sv ====
// pad function multiplexer for four eight-pin ports
// What this block does
// - after reset a5:0 and b3:2 are gpio, c3:0 alternate, and every other pin is digitally disabled.
// - an analog mode bit per pin hands the pin to its analog function while its digital enable is clear.
// - a pin carries an alternate function only while its select bit is set.
// - a per-pin mux code picks which peripheral owns an alternate pin.
// - power-on or pin reset returns every selection to its default.
// - a1:0 uart, a5:2 serial, b3:2 i2c at code 1; c3:0 debug, select, code 3.
// - port d bit 0 offers gpio, adc 15, cmp 0, i2c7 clock, ssi2 d1, t0 ccp0.
// - port d bit 1 offers gpio, adc 14, cmp 1, i2c7 data, ssi2 d0, t0 ccp1.
`timescale 1ns/1ps
`default_nettype none
`include "pfm_defines.svh"
module pfm_pad_mux (
    input wire logic i_clock,
    input wire logic i_rst,
    input wire logic i_cfg_we,
    input wire logic [1:0] i_cfg_port,
    input wire pfm_pkg::pfm_field_type i_cfg_field,
    input wire logic [31:0] i_cfg_wdata,
    input wire logic [1:0] i_rd_port,
    input wire pfm_pkg::pfm_field_type i_rd_field,
    output logic [31:0] o_cfg_rdata,
    input wire logic [31:0] i_gpio_out,
    input wire logic [31:0] i_gpio_oe,
    output logic [31:0] o_gpio_in,
    input wire logic [511:0] i_alt_out,
    input wire logic [511:0] i_alt_oe,
    output logic [511:0] o_alt_in,
    input wire logic i_comparator0_out,
    input wire logic i_comparator1_out,
    input wire logic i_i2c_module7_clock_out,
    input wire logic i_i2c_module7_clock_oe,
    output logic o_i2c_module7_clock_in,
    input wire logic i_i2c_module7_data_out,
    input wire logic i_i2c_module7_data_oe,
    output logic o_i2c_module7_data_in,
    input wire logic i_sync_serial2_data1_out,
    input wire logic i_sync_serial2_data1_oe,
    output logic o_sync_serial2_data1_in,
    input wire logic i_sync_serial2_data0_out,
    input wire logic i_sync_serial2_data0_oe,
    output logic o_sync_serial2_data0_in,
    input wire logic i_timer0_capture_compare0_out,
    input wire logic i_timer0_capture_compare0_oe,
    output logic o_timer0_capture_compare0_in,
    input wire logic i_timer0_capture_compare1_out,
    input wire logic i_timer0_capture_compare1_oe,
    output logic o_timer0_capture_compare1_in,
    output logic [31:0] o_adc_connect,
    output logic [31:0] o_analog_direct,
    input wire logic [31:0] i_pad_in,
    output logic [31:0] o_pad_out,
    output logic [31:0] o_pad_oe
);
    localparam int NPORT = `PFM_PORT_COUNT;
    localparam int PPW = `PFM_PINS_PER_PORT;
    localparam int NPIN = NPORT * PPW;
    localparam int NCODE = `PFM_CODE_COUNT;
    localparam int DB0 = `PFM_DB0_IDX;
    localparam int DB1 = `PFM_DB1_IDX;
    localparam logic [31:0] PCTL_RST [NPORT] = '{`PFM_PORT_A_PCTL_RST,
        `PFM_PORT_B_PCTL_RST, `PFM_PORT_C_PCTL_RST, `PFM_PORT_D_PCTL_RST};
    localparam logic [7:0] AFSEL_RST [NPORT] = '{`PFM_PORT_A_AFSEL_RST,
        `PFM_PORT_B_AFSEL_RST, `PFM_PORT_C_AFSEL_RST, `PFM_PORT_D_AFSEL_RST};
    localparam logic [7:0] DIGEN_RST [NPORT] = '{`PFM_PORT_A_DIGEN_RST,
        `PFM_PORT_B_DIGEN_RST, `PFM_PORT_C_DIGEN_RST, `PFM_PORT_D_DIGEN_RST};

    logic [31:0] digen_all, anasel_all, afsel_all;
    logic [127:0] pctl_all;
    logic [511:0] src_out, src_oe;
    logic [31:0] pad_out_r, pad_out_nxt, pad_oe_r, pad_oe_nxt;
    logic [31:0] gpio_in_r, gpio_in_nxt, adc_r, adc_nxt, direct_r, direct_nxt;
    logic [511:0] alt_in_r, alt_in_nxt;
    logic [31:0] rdata_r, rdata_nxt;
    logic first_r;

    // mux code of one pin out of the flat port control vector
    function automatic logic [3:0] pin_code(input logic [127:0] pctl,
                                            input int pin);
        pin_code = pctl[pin*4 +: 4];
    endfunction

    // slot of one pin and code in the flat peripheral vectors
    function automatic int slot(input int pin, input logic [3:0] code);
        slot = pin * NCODE + int'(code);
    endfunction

    // one register bank per port, each with its own defaults
    genvar g;
    generate
        for (g = 0; g < NPORT; g++) begin : g_port
            pfm_port_cfg #(
                .DIGEN_RST(DIGEN_RST[g]),
                .AFSEL_RST(AFSEL_RST[g]),
                .ANASEL_RST(`PFM_ANASEL_RST),
                .PCTL_RST(PCTL_RST[g])
            ) u_cfg (
                .i_clock(i_clock),
                .i_rst(i_rst),
                .i_we(i_cfg_we && i_cfg_port == 2'(g)),
                .i_field(i_cfg_field),
                .i_wdata(i_cfg_wdata),
                .o_digen(digen_all[g*PPW +: PPW]),
                .o_anasel(anasel_all[g*PPW +: PPW]),
                .o_afsel(afsel_all[g*PPW +: PPW]),
                .o_pctl(pctl_all[g*32 +: 32])
            );
        end
    endgenerate

    // source table; port d bits 0 and 1 use their own peripheral ports
    always_comb begin
        src_out = i_alt_out;
        src_oe = i_alt_oe;
        src_out[slot(DB0, `PFM_CODE_CMP_OUT)] = i_comparator0_out;
        src_oe[slot(DB0, `PFM_CODE_CMP_OUT)] = 1'b1;
        src_out[slot(DB0, `PFM_CODE_I2C)] = i_i2c_module7_clock_out;
        src_oe[slot(DB0, `PFM_CODE_I2C)] = i_i2c_module7_clock_oe;
        src_out[slot(DB0, `PFM_CODE_SSI)] = i_sync_serial2_data1_out;
        src_oe[slot(DB0, `PFM_CODE_SSI)] = i_sync_serial2_data1_oe;
        src_out[slot(DB0, `PFM_CODE_TIMER)] = i_timer0_capture_compare0_out;
        src_oe[slot(DB0, `PFM_CODE_TIMER)] = i_timer0_capture_compare0_oe;
        src_out[slot(DB1, `PFM_CODE_CMP_OUT)] = i_comparator1_out;
        src_oe[slot(DB1, `PFM_CODE_CMP_OUT)] = 1'b1;
        src_out[slot(DB1, `PFM_CODE_I2C)] = i_i2c_module7_data_out;
        src_oe[slot(DB1, `PFM_CODE_I2C)] = i_i2c_module7_data_oe;
        src_out[slot(DB1, `PFM_CODE_SSI)] = i_sync_serial2_data0_out;
        src_oe[slot(DB1, `PFM_CODE_SSI)] = i_sync_serial2_data0_oe;
        src_out[slot(DB1, `PFM_CODE_TIMER)] = i_timer0_capture_compare1_out;
        src_oe[slot(DB1, `PFM_CODE_TIMER)] = i_timer0_capture_compare1_oe;
    end

    // per-pin routing; analog or disabled pins never drive the pad
    always_comb begin
        logic [3:0] code;
        code = 4'h0;
        pad_out_nxt = '0;
        pad_oe_nxt = '0;
        gpio_in_nxt = '0;
        alt_in_nxt = '0;
        for (int p = 0; p < NPIN; p++) begin
            code = pin_code(pctl_all, p);
            adc_nxt[p] = anasel_all[p] && !digen_all[p];
            direct_nxt[p] = !digen_all[p];
            if (digen_all[p] && !anasel_all[p]) begin
                if (afsel_all[p]) begin
                    pad_out_nxt[p] = src_out[slot(p, code)];
                    pad_oe_nxt[p] = src_oe[slot(p, code)];
                    alt_in_nxt[slot(p, code)] = i_pad_in[p];
                end else begin
                    pad_out_nxt[p] = i_gpio_out[p];
                    pad_oe_nxt[p] = i_gpio_oe[p];
                end
                gpio_in_nxt[p] = i_pad_in[p];
            end
        end
    end

    // readback of the selected port and field
    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (i_rd_field == pfm_pkg::PFM_FIELD_DIGEN) begin
            rdata_nxt[7:0] = digen_all[i_rd_port*PPW +: PPW];
        end else if (i_rd_field == pfm_pkg::PFM_FIELD_ANASEL) begin
            rdata_nxt[7:0] = anasel_all[i_rd_port*PPW +: PPW];
        end else if (i_rd_field == pfm_pkg::PFM_FIELD_AFSEL) begin
            rdata_nxt[7:0] = afsel_all[i_rd_port*PPW +: PPW];
        end else begin
            rdata_nxt = pctl_all[i_rd_port*32 +: 32];
        end
    end

    // one flop stage on every output keeps pad timing independent of config
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            pad_out_r <= '0;
            pad_oe_r <= '0;
            gpio_in_r <= '0;
            alt_in_r <= '0;
            adc_r <= '0;
            direct_r <= '0;
            rdata_r <= '0;
            first_r <= 1'b1;
        end else begin
            pad_out_r <= pad_out_nxt;
            pad_oe_r <= pad_oe_nxt;
            gpio_in_r <= gpio_in_nxt;
            alt_in_r <= alt_in_nxt;
            adc_r <= adc_nxt;
            direct_r <= direct_nxt;
            rdata_r <= rdata_nxt;
            first_r <= 1'b0;
        end
    end

    assign o_pad_out = pad_out_r;
    assign o_pad_oe = pad_oe_r;
    assign o_gpio_in = gpio_in_r;
    assign o_alt_in = alt_in_r;
    assign o_adc_connect = adc_r;
    assign o_analog_direct = direct_r;
    assign o_cfg_rdata = rdata_r;
    assign o_i2c_module7_clock_in = alt_in_r[slot(DB0, `PFM_CODE_I2C)];
    assign o_sync_serial2_data1_in = alt_in_r[slot(DB0, `PFM_CODE_SSI)];
    assign o_timer0_capture_compare0_in = alt_in_r[slot(DB0, `PFM_CODE_TIMER)];
    assign o_i2c_module7_data_in = alt_in_r[slot(DB1, `PFM_CODE_I2C)];
    assign o_sync_serial2_data0_in = alt_in_r[slot(DB1, `PFM_CODE_SSI)];
    assign o_timer0_capture_compare1_in = alt_in_r[slot(DB1, `PFM_CODE_TIMER)];

    default clocking cb @(posedge i_clock); endclocking
    default disable iff (i_rst);

    sequence s_db0_cmp;
        afsel_all[DB0] && digen_all[DB0] && !anasel_all[DB0]
            && pin_code(pctl_all, DB0) == `PFM_CODE_CMP_OUT;
    endsequence
    sequence s_db1_timer;
        afsel_all[DB1] && digen_all[DB1] && !anasel_all[DB1]
            && pin_code(pctl_all, DB1) == `PFM_CODE_TIMER;
    endsequence

    a_reset_defaults: assert property (first_r |->
        pctl_all[95:64] == `PFM_PORT_C_PCTL_RST
        && afsel_all[23:16] == `PFM_PORT_C_AFSEL_RST
        && pctl_all[31:0] == `PFM_PORT_A_PCTL_RST)
        else $error("defaults wrong after reset");
    a_gpio_after_reset: assert property (first_r |->
        afsel_all[31:24] == 8'h00 && afsel_all[7:0] == 8'h00)
        else $error("plain pins not gpio after reset");
    a_db0_comparator: assert property (s_db0_cmp |=>
        o_pad_out[DB0] == $past(i_comparator0_out) && o_pad_oe[DB0])
        else $error("port d bit 0 comparator route wrong");
    a_db1_timer: assert property (s_db1_timer ##1 s_db1_timer |->
        o_pad_out[DB1] == $past(i_timer0_capture_compare1_out)
        && o_timer0_capture_compare1_in == $past(i_pad_in[DB1]))
        else $error("port d bit 1 timer route wrong");

    generate
        for (g = 0; g < NPIN; g++) begin : g_chk
            a_analog_no_drive: assert property (anasel_all[g] |=>
                !o_pad_oe[g] && o_adc_connect[g] == !$past(digen_all[g]))
                else $error("analog pin still driven");
            a_gpio_owns_pin: assert property (
                !afsel_all[g] && digen_all[g] && !anasel_all[g] |=>
                o_pad_out[g] == $past(i_gpio_out[g])
                && o_pad_oe[g] == $past(i_gpio_oe[g]))
                else $error("gpio route wrong");
            a_alt_code_route: assert property (
                afsel_all[g] && digen_all[g] && !anasel_all[g] |=>
                o_pad_oe[g] == $past(src_oe[slot(g, pin_code(pctl_all, g))]))
                else $error("alternate enable route wrong");
            a_input_gated: assert property (!digen_all[g] |=>
                !o_gpio_in[g] && o_alt_in[g*NCODE +: NCODE] == 16'h0000
                && !o_pad_oe[g])
                else $error("disabled pin not gated");
        end
    endgenerate
endmodule // pfm_pad_mux
`default_nettype wire

// ==== pfm_periph_model.sv ====
// behavioural model of the peripherals and gpio logic behind the pads
`timescale 1ns/1ps
`default_nettype none
module pfm_periph_model (
    input wire logic i_step,
    output logic [31:0] o_gpio_out,
    output logic [31:0] o_gpio_oe,
    output logic [511:0] o_alt_out,
    output logic [511:0] o_alt_oe,
    output logic [1:0] o_cmp,
    output logic [5:0] o_spec_out,
    output logic [5:0] o_spec_oe
);
    logic [31:0] st;

    // xorshift, so every step shows fresh drive on every slot
    function automatic logic [31:0] nx(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    // drive moves only on the step strobe, never on the sampling edge
    initial begin
        st = 32'h3c5a_9e71;
        forever begin
            for (int k = 0; k < 16; k++) begin
                st = nx(st);
                o_alt_out[k*32+:32] = st;
                st = nx(st);
                o_alt_oe[k*32+:32] = st;
            end
            st = nx(st);
            o_gpio_out = st;
            st = nx(st);
            o_gpio_oe = st;
            st = nx(st);
            o_cmp = st[1:0];
            o_spec_out = st[7:2];
            o_spec_oe = st[13:8]; // push-pull drive only, no open drain
            @(posedge i_step);
        end
    end
endmodule // pfm_periph_model
`default_nettype wire

// ==== test_pad_function_mux.sv ====
// self-checking bench for the pad function multiplexer
`timescale 1ns/1ps
`default_nettype none
`include "pfm_defines.svh"
module test_pad_function_mux;
    logic i_clock, i_rst, we, step;
    logic [1:0] wport, rport, cmp;
    pfm_pkg::pfm_field_type wfield, rfield;
    logic [31:0] wdata, rdata, pad_in, g_out, g_oe, g_in, p_out, p_oe;
    logic [31:0] adc, adir, lfsr, r;
    logic [511:0] a_out, a_oe, a_in;
    logic [5:0] s_out, s_oe;
    wire [5:0] s_in;
    logic [7:0] digen_m[4], am_m[4], af_m[4];
    logic [31:0] pc_m[4];
    logic [3:0] codes[5] = '{4'h9, 4'h2, 4'hf, 4'h3, 4'h1};
    int n_fail, samples_checked;

    pfm_pad_mux pfm_pad_mux_i (
        .i_clock(i_clock), .i_rst(i_rst), .i_cfg_we(we), .i_cfg_port(wport),
        .i_cfg_field(wfield), .i_cfg_wdata(wdata), .i_rd_port(rport),
        .i_rd_field(rfield), .o_cfg_rdata(rdata), .i_gpio_out(g_out),
        .i_gpio_oe(g_oe), .o_gpio_in(g_in), .i_alt_out(a_out),
        .i_alt_oe(a_oe), .o_alt_in(a_in), .i_comparator0_out(cmp[0]),
        .i_comparator1_out(cmp[1]), .i_i2c_module7_clock_out(s_out[0]),
        .i_i2c_module7_clock_oe(s_oe[0]), .o_i2c_module7_clock_in(s_in[0]),
        .i_i2c_module7_data_out(s_out[1]), .i_i2c_module7_data_oe(s_oe[1]),
        .o_i2c_module7_data_in(s_in[1]), .i_sync_serial2_data1_out(s_out[2]),
        .i_sync_serial2_data1_oe(s_oe[2]), .o_sync_serial2_data1_in(s_in[2]),
        .i_sync_serial2_data0_out(s_out[3]), .i_sync_serial2_data0_oe(s_oe[3]),
        .o_sync_serial2_data0_in(s_in[3]),
        .i_timer0_capture_compare0_out(s_out[4]),
        .i_timer0_capture_compare0_oe(s_oe[4]),
        .o_timer0_capture_compare0_in(s_in[4]),
        .i_timer0_capture_compare1_out(s_out[5]),
        .i_timer0_capture_compare1_oe(s_oe[5]),
        .o_timer0_capture_compare1_in(s_in[5]), .o_adc_connect(adc),
        .o_analog_direct(adir), .i_pad_in(pad_in), .o_pad_out(p_out),
        .o_pad_oe(p_oe));

    pfm_periph_model pfm_periph_model_i (
        .i_step(step), .o_gpio_out(g_out), .o_gpio_oe(g_oe), .o_alt_out(a_out),
        .o_alt_oe(a_oe), .o_cmp(cmp), .o_spec_out(s_out), .o_spec_oe(s_oe));

    function automatic logic [31:0] rnd();
        lfsr = lfsr[0] ? (lfsr >> 1) ^ 32'h8020_0003 : lfsr >> 1;
        return lfsr;
    endfunction

    task automatic cmp32(input logic [31:0] got, input logic [31:0] want);
        samples_checked++;
        if (got !== want) begin
            n_fail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask

    task automatic cmp512(input logic [511:0] got, input logic [511:0] want);
        samples_checked++;
        if (got !== want) begin
            n_fail++;
            $display("mismatch t=%0t got=%h exp=%h", $time, got, want);
        end
    endtask

    task automatic complete_run();
        $display("checked %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // reset defaults of the shadow selection
    task automatic init_model();
        digen_m = '{`PFM_PORT_A_DIGEN_RST, `PFM_PORT_B_DIGEN_RST,
                    `PFM_PORT_C_DIGEN_RST, `PFM_PORT_D_DIGEN_RST};
        am_m = '{8'h00, 8'h00, 8'h00, 8'h00};
        af_m = '{8'h00, 8'h00, 8'h0f, 8'h00};
        pc_m = '{32'h0011_1111, 32'h0000_1100, 32'h0000_3333, 32'h0};
    endtask

    task automatic rst_pulse();
        i_rst = 1'b1;
        we = 1'b0;
        init_model();
        repeat (2) @(negedge i_clock);
        i_rst = 1'b0;
    endtask

    // strobe stays up, so consecutive calls write on consecutive edges
    task automatic wr(input logic [1:0] pt, input logic [1:0] f,
                      input logic [31:0] d);
        @(negedge i_clock);
        we = 1'b1;
        wport = pt;
        wfield = pfm_pkg::pfm_field_type'(f);
        wdata = d;
        case (f)
            2'd0: digen_m[pt] = d[7:0];
            2'd1: am_m[pt] = d[7:0];
            2'd2: af_m[pt] = d[7:0];
            default: pc_m[pt] = d;
        endcase
    endtask

    task automatic rb(input logic [1:0] pt, input logic [1:0] f);
        logic [31:0] e;
        @(negedge i_clock);
        we = 1'b0;
        rport = pt;
        rfield = pfm_pkg::pfm_field_type'(f);
        e = (f == 2'd0) ? {24'h0, digen_m[pt]}
          : (f == 2'd1) ? {24'h0, am_m[pt]}
          : (f == 2'd2) ? {24'h0, af_m[pt]} : pc_m[pt];
        repeat (2) @(negedge i_clock);
        cmp32(rdata, e);
    endtask

    task automatic rb_all();
        for (int p = 0; p < 4; p++) begin
            for (int f = 0; f < 4; f++) begin
                rb(2'(p), 2'(f));
            end
        end
    endtask

    // new drive and pad levels, let the routing settle, then compare
    task automatic check();
        logic [31:0] eo, ee, eg, ea, ed;
        logic [511:0] ei, m;
        logic [5:0] es;
        logic [3:0] c;
        logic dg, af, so, se;
        int s, j;
        @(negedge i_clock);
        we = 1'b0;
        step = 1'b1;
        pad_in = rnd();
        @(negedge i_clock);
        step = 1'b0;
        repeat (3) @(negedge i_clock);
        ei = '0;
        m = '1;
        es = '0;
        for (int p = 0; p < 32; p++) begin
            c = pc_m[p/8][(p%8)*4+:4];
            dg = digen_m[p/8][p%8] & ~am_m[p/8][p%8];
            af = af_m[p/8][p%8];
            s = p * 16 + c;
            so = af ? a_out[s] : g_out[p];
            se = af ? a_oe[s] : g_oe[p];
            if (p > 23 && p < 26 && af) begin
                j = (c == 4'h2) ? 0 : (c == 4'hf) ? 2 : (c == 4'h3) ? 4 : 9;
                if (j < 9 || c == 4'h9) m[s] = 1'b0;
                if (c == 4'h9) begin
                    so = cmp[p-24];
                    se = 1'b1;
                end else if (j < 9) begin
                    so = s_out[j+p-24];
                    se = s_oe[j+p-24];
                    es[j+p-24] = pad_in[p] & dg;
                end
            end
            ee[p] = dg & se;
            eo[p] = dg & se & so;
            eg[p] = pad_in[p] & dg;
            ei[s] = pad_in[p] & dg & af;
            ea[p] = am_m[p/8][p%8] & ~digen_m[p/8][p%8];
            ed[p] = ~digen_m[p/8][p%8];
        end
        cmp32(p_oe, ee);
        cmp32(p_out & ee, eo);
        cmp32(g_in, eg);
        cmp32(adc, ea);
        cmp32(adir, ed);
        cmp512(a_in & m, ei & m);
        cmp32({26'h0, s_in}, {26'h0, es});
    endtask

    // free-running clock
    initial begin
        i_clock = 1'b0;
        forever #25 i_clock = ~i_clock;
    end

    // hang guard, far beyond the at most 1657 cycles the run needs
    initial begin
        #1000000;
        n_fail++;
        complete_run();
    end

    // directed corners, random traffic, then a reset in mid-run
    initial begin
        lfsr = 32'he7af;
        n_fail = 0;
        samples_checked = 0;
        step = 1'b0;
        wport = 2'd0;
        wfield = pfm_pkg::PFM_FIELD_DIGEN;
        wdata = '0;
        rport = 2'd0;
        rfield = pfm_pkg::PFM_FIELD_DIGEN;
        pad_in = '0;
        rst_pulse();
        check();
        rb_all();
        wr(2'd3, 2'd0, 32'h0000_0003);
        wr(2'd3, 2'd1, 32'h0000_0000);
        wr(2'd3, 2'd2, 32'h0000_0003);
        foreach (codes[i]) begin
            wr(2'd3, 2'd3, {24'h0, codes[i], codes[i]});
            check();
        end
        wr(2'd3, 2'd0, 32'h0000_0000);
        wr(2'd3, 2'd1, 32'h0000_0003);
        check();
        wr(2'd3, 2'd1, 32'h0000_0001);
        check();
        repeat (150) begin
            r = rnd();
            wr(r[1:0], r[3:2], rnd());
            if (r[4]) wr(r[6:5], r[8:7], rnd());
            check();
            if (r[9]) rb(r[11:10], r[13:12]);
        end
        @(negedge i_clock);
        rst_pulse();
        check();
        rb_all();
        complete_run();
    end
endmodule // test_pad_function_mux
`default_nettype wire
